/* File: core/timer8_pkg.sv */
// Shared constants and types for the 8-bit timer with shared prescaler
package timer8_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_COUNT = 8'h01;
    localparam logic [7:0] IDX_INTCTL = 8'h0B;
    localparam logic [7:0] IDX_OPTION = 8'h81;
    localparam logic [7:0] IDX_CTRL = 8'h90;

    // Reset values
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // Interrupt control fields
    localparam int INTCTL_FLAG_BIT = 2;
    localparam int INTCTL_EN_BIT = 5;

    // Block control fields
    localparam int CTRL_SLEEP_BIT = 0;
    localparam int CTRL_WDT_CLEAR_BIT = 1;

    // Counting constants
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [1:0] WRITE_INHIBIT_INSTR = 2'h2;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    localparam int CLK_PERIOD_NS = 10;

    // Option register fields, bit 7 first
    typedef struct packed {
        logic port_pullup_disable;
        logic ext_irq_edge_select;
        logic count_source_select;
        logic count_edge_select;
        logic prescaler_owner_select;
        logic [2:0] prescale_rate_code;
    } option_s;

    // Captured bus address phase
    typedef struct packed {
        logic wr;
        logic ok;
        logic [7:0] idx;
    } bus_req_s;

endpackage

/* File: core/timer8_shared_prescaler.sv */
// 8-bit timer/counter with prescaler shared with the watchdog, AHB-Lite slave
// What this block does
// - Eight-bit counter wraps FFh to 00h; each wrap is an overflow event.
// - Internal source: advance once per instruction cycle, prescaled only if assigned.
// - After a count write, no increments for the next two instruction cycles.
// - External source: count pin edges; edge bit 0 rising, 1 falling.
// - One prescaler, one owner: bit 3 high watchdog, low the counter.
// - Software can neither read nor load the prescaler count.
// - Rate code: counter 1:2 up to 1:256, watchdog 1:1 up to 1:128.
// - Count write clears prescaler when the counter owns it; owner unchanged.
// - Watchdog clear clears prescaler when the watchdog owns it.
// - Overflow sets flag bit 2; enable bit 5 gates request; software clears.
// - Counter stopped in Sleep, so no overflow wake-up.
// - External clock sampled after the prescaler on Q2 and Q4 phases.
// - Option bit 7 high disables port pull-ups, low enables them.
// - Option bit 6 picks external interrupt edge: 1 rising, 0 falling.
module timer8_shared_prescaler (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Count pin and watchdog
    input wire logic ext_count_clock_pin,
    input wire logic wdt_base_tick,
    output logic wdt_tick,
    output logic wdt_clear,
    // Interrupt and port controls
    output logic overflow_irq,
    output logic port_pullup_disable,
    output logic ext_irq_edge_select
);

    timer8_pkg::option_s option_q;
    timer8_pkg::option_s option_d;
    timer8_pkg::bus_req_s req_q;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] pre_q;
    logic [7:0] pre_d;
    logic [1:0] phase_q;
    logic [1:0] inhibit_q;
    logic [1:0] inhibit_d;
    logic flag_q;
    logic flag_d;
    logic irq_en_q;
    logic sleep_q;
    logic pend_q;
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;
    logic ext_lvl_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic wdt_tick_q;
    logic wdt_clear_q;
    logic irq_q;

    // Bus decode
    wire addr_ok = (haddr[31:10] == 22'h0);
    wire ap_valid = hsel & htrans[1] & hready;
    wire ap_read = ap_valid & ~hwrite;
    wire [7:0] ap_idx = haddr[9:2];
    wire wr_count = req_q.wr & req_q.ok & (req_q.idx == timer8_pkg::IDX_COUNT);
    wire wr_intctl = req_q.wr & req_q.ok & (req_q.idx == timer8_pkg::IDX_INTCTL);
    wire wr_option = req_q.wr & req_q.ok & (req_q.idx == timer8_pkg::IDX_OPTION);
    wire wr_ctrl = req_q.wr & req_q.ok & (req_q.idx == timer8_pkg::IDX_CTRL);
    wire wdt_clr_cmd = wr_ctrl & hwdata[timer8_pkg::CTRL_WDT_CLEAR_BIT];

    // Instruction cycle phases
    wire instr_tick = (phase_q == timer8_pkg::PHASE_Q4);
    wire sample = (phase_q == timer8_pkg::PHASE_Q2) | instr_tick;

    // External pin filtered edges
    wire ext_agree = (ext_s2_q == ext_s3_q);
    wire ext_rise = ext_agree & ext_s3_q & ~ext_lvl_q;
    wire ext_fall = ext_agree & ~ext_s3_q & ext_lvl_q;
    wire ext_edge = option_q.count_edge_select ? ext_fall : ext_rise;

    // source choice; no source in Sleep
    wire tsrc = ~sleep_q & (option_q.count_source_select ? ext_edge : instr_tick);

    wire owner_wdt = option_q.prescaler_owner_select;
    wire pre_src = owner_wdt ? wdt_base_tick : tsrc;
    // ratio: counter one step more than watchdog
    wire [3:0] pre_bits = owner_wdt ? {1'b0, option_q.prescale_rate_code}
                                    : {1'b0, option_q.prescale_rate_code} + 4'h1;
    wire [8:0] pre_mask9 = (9'h001 << pre_bits) - 9'h001;
    wire [7:0] pre_mask = pre_mask9[7:0];
    wire pre_fire = pre_src & ((pre_q & pre_mask) == pre_mask);
    wire pre_clr = (wr_count & ~owner_wdt) | (wdt_clr_cmd & owner_wdt);

    wire timer_evt = owner_wdt ? tsrc : pre_fire;
    wire inc = pend_q & sample & (inhibit_q == 2'h0) & ~sleep_q & ~wr_count;
    wire overflow = inc & (count_q == timer8_pkg::COUNT_MAX);

    wire [7:0] rd_byte =
        !addr_ok ? 8'h00 :
        (ap_idx == timer8_pkg::IDX_COUNT) ? count_q :
        (ap_idx == timer8_pkg::IDX_INTCTL) ?
            {2'h0, irq_en_q, 2'h0, flag_q, 2'h0} :
        (ap_idx == timer8_pkg::IDX_OPTION) ? option_q :
        (ap_idx == timer8_pkg::IDX_CTRL) ? {7'h00, sleep_q} : 8'h00;

    // Next values
    always_comb
    begin
        count_d = count_q;
        if (wr_count)
            count_d = hwdata[7:0];
        else if (inc)
            count_d = count_q + 8'h01;
    end

    always_comb
    begin
        pre_d = pre_q;
        if (pre_clr)
            pre_d = 8'h00;
        else if (pre_src)
            pre_d = pre_q + 8'h01;
    end

    always_comb
    begin
        inhibit_d = inhibit_q;
        // two instruction cycles
        // Counted in Q2 increment slots, so the next two Q2 slots and any Q4 slots between them give no increment
        if (wr_count)
            inhibit_d = timer8_pkg::WRITE_INHIBIT_INSTR;
        else if (phase_q == timer8_pkg::PHASE_Q2 && inhibit_q != 2'h0)
            inhibit_d = inhibit_q - 2'h1;
    end

    assign flag_d = overflow | (wr_intctl ? hwdata[timer8_pkg::INTCTL_FLAG_BIT] : flag_q);
    assign option_d = wr_option ? timer8_pkg::option_s'(hwdata[7:0]) : option_q;

    // Bus slave
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req_q <= '0;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b0;
        end
        else
        begin
            req_q <= '{wr: ap_valid & hwrite, ok: addr_ok, idx: ap_idx};
            hrdata_q <= ap_read ? {24'h000000, rd_byte} : 32'h0000_0000;
            hreadyout_q <= 1'b1;
        end
    end

    // Registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            option_q <= timer8_pkg::option_s'(timer8_pkg::OPTION_RESET);
            count_q <= timer8_pkg::COUNT_RESET;
            flag_q <= 1'b0;
            irq_en_q <= 1'b0;
            sleep_q <= 1'b0;
        end
        else
        begin
            option_q <= option_d;
            count_q <= count_d;
            flag_q <= flag_d;
            irq_en_q <= wr_intctl ? hwdata[timer8_pkg::INTCTL_EN_BIT] : irq_en_q;
            sleep_q <= wr_ctrl ? hwdata[timer8_pkg::CTRL_SLEEP_BIT] : sleep_q;
        end
    end

    // Timing state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_q <= 2'h0;
            pre_q <= 8'h00;
            inhibit_q <= 2'h0;
            pend_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_q + 2'h1;
            pre_q <= pre_d;
            inhibit_q <= inhibit_d;
            // event held until next sample point
            pend_q <= timer_evt | (pend_q & ~sample);
        end
    end

    // pin synchroniser, level counts when stages agree
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            ext_lvl_q <= 1'b0;
        end
        else
        begin
            ext_s1_q <= ext_count_clock_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            ext_lvl_q <= ext_agree ? ext_s3_q : ext_lvl_q;
        end
    end

    // Outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wdt_tick_q <= 1'b0;
            wdt_clear_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            wdt_tick_q <= owner_wdt ? pre_fire : wdt_base_tick;
            wdt_clear_q <= wdt_clr_cmd;
            irq_q <= flag_d & irq_en_q;
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = 1'b0;
    assign wdt_tick = wdt_tick_q;
    assign wdt_clear = wdt_clear_q;
    assign overflow_irq = irq_q;
    assign port_pullup_disable = option_q.port_pullup_disable;
    assign ext_irq_edge_select = option_q.ext_irq_edge_select;

    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_wrap;
        inc && count_q == timer8_pkg::COUNT_MAX;
    endsequence

    sequence s_wrapped;
        count_q == 8'h00 && flag_q;
    endsequence

    a_wrap_sets_flag: assert property (s_wrap |=> s_wrapped)
        else $error("Wrap did not give zero and flag");

    a_flag_held: assert property (flag_q && !wr_intctl |=> flag_q)
        else $error("Overflow flag dropped without software");

    a_irq_gated: assert property (irq_q |-> $past(irq_en_q))
        else $error("Request without enable");

    a_write_inhibit: assert property (wr_count |=> !inc [*4])
        else $error("Count advanced right after write");

    a_sleep_stop: assert property (sleep_q |-> !inc)
        else $error("Counter advanced in Sleep");

    a_timer_tick: assert property (instr_tick && !option_q.count_source_select
        && owner_wdt && !sleep_q |=> pend_q)
        else $error("Instruction tick not counted");

    a_pre_clear_wr: assert property (wr_count && !owner_wdt |=> pre_q == 8'h00)
        else $error("Count write left prescaler");

    a_pre_clear_wdt: assert property (wdt_clr_cmd && owner_wdt |=> pre_q == 8'h00)
        else $error("Watchdog clear left prescaler");

    a_wdt_undivided: assert property (!owner_wdt && wdt_base_tick |=> wdt_tick_q)
        else $error("Watchdog tick divided without prescaler");

    a_min_ratio: assert property (!owner_wdt && pre_fire |-> pre_q[0])
        else $error("Counter prescale below 1:2");

    sequence s_count_write;
        wr_count;
    endsequence

    sequence s_no_rewrite;
        !wr_count [*4];
    endsequence

    a_count_frozen: assert property (s_count_write ##1 s_no_rewrite
        |=> count_q == $past(count_q, 4))
        else $error("Count moved inside write hold-off");

    a_count_load: assert property (wr_count |=> count_q == $past(hwdata[7:0]))
        else $error("Count write not loaded");

    a_owner_kept: assert property (wr_count |=> $stable(option_q))
        else $error("Count write changed prescaler owner");

    a_irq_follows: assert property (flag_q && irq_en_q && !wr_intctl |=> irq_q)
        else $error("Enabled flag gave no request");

    a_irq_masked: assert property (!irq_en_q |=> !irq_q)
        else $error("Request while disabled");

    a_sleep_hold: assert property (sleep_q && !wr_count |=> $stable(count_q))
        else $error("Count changed in Sleep");

    a_read_count: assert property (ap_read && addr_ok && ap_idx == timer8_pkg::IDX_COUNT
        |=> hrdata_q == {24'h000000, $past(count_q)})
        else $error("Count read back wrong");

    a_unmapped_zero: assert property (ap_read && !addr_ok |=> hrdata_q == 32'h0000_0000)
        else $error("Unmapped read not zero");

    a_wdt_prescaled: assert property (owner_wdt && !wdt_base_tick |=> !wdt_tick_q)
        else $error("Watchdog tick without base tick");

    a_pend_cleared: assert property (pend_q && sample && !timer_evt |=> !pend_q)
        else $error("Pending event kept past sample point");

endmodule

/* File: verification/count_source_model.sv */
// Far-side model: external count clock source and watchdog base tick
module count_source_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench requests
    input wire logic go,
    input wire logic [7:0] toggles,
    // Far side
    output logic pin,
    output logic base_tick,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] left_q;
    logic [2:0] hold_q;
    logic [1:0] div_q;
    assign busy = left_q != 8'h00;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            left_q <= 8'h00;
            hold_q <= 3'h0;
            div_q <= 2'h0;
            pin <= 1'b0;
            base_tick <= 1'b0;
        end
        else
        begin
            div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
            base_tick <= div_q == 2'h2;
            hold_q <= hold_q + 3'h1;
            if (go)
                left_q <= toggles;
            else if (busy && hold_q == 3'h7)
            begin
                pin <= ~pin;
                left_q <= left_q - 8'h01;
            end
        end
    end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the timer with shared prescaler
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CNT = timer8_pkg::IDX_COUNT;
    localparam logic [7:0] ICT = timer8_pkg::IDX_INTCTL;
    localparam logic [7:0] OPT = timer8_pkg::IDX_OPTION;
    localparam logic [7:0] CTL = timer8_pkg::IDX_CTRL;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic [7:0] toggles = 8'h00, v;
    logic [15:0] seed = 16'h0001;
    logic hready, hresp, pin, base_tick, busy, wdt_tick, wdt_clear, irq, pud, ies;
    int n_fail = 0, check_count = 0, cyc = 0, wt = 0, wc = 0, w0, c0;
    timer8_shared_prescaler timer8_shared_prescaler_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .ext_count_clock_pin(pin),
        .wdt_base_tick(base_tick), .wdt_tick(wdt_tick), .wdt_clear(wdt_clear),
        .overflow_irq(irq), .port_pullup_disable(pud), .ext_irq_edge_select(ies)
    );
    count_source_model count_source_model_inst (
        .hclk(hclk), .hresetn(hresetn), .go(go), .toggles(toggles), .pin(pin),
        .base_tick(base_tick), .busy(busy)
    );
    task automatic stop_test();
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input int tol);
        check_count++;
        if (!(got === want || (tol > 0 && (got === want + 1 || got === want - 1))))
        begin
            n_fail++;
            $display("Error at %0t: got %0h want %0h", $time, got, want);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic pulses(input logic [7:0] n);
        repeat (12) @(posedge hclk);
        toggles <= n;
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        do @(posedge hclk); while (busy === 1'b1);
        repeat (12) @(posedge hclk);
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Increments after w idle cycles past a count write, two instruction cycles held off
    function automatic int incs(input int w, input int sh);
        return ((w + 2) / 4 - 2) >> sh;
    endfunction
    initial
    begin
        forever #(timer8_pkg::CLK_PERIOD_NS / 2) hclk = ~hclk;
    end
    always @(negedge hclk)
    begin
        cyc++;
        if (wdt_tick === 1'b1)
            wt++;
        if (wdt_clear === 1'b1)
            wc++;
        if (cyc == 60000)
        begin
            n_fail++;
            stop_test();
        end
    end
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, OPT, 8'h00);
        chk(r, {24'h0, timer8_pkg::OPTION_RESET}, 0);
        chk({30'h0, pud, ies}, 32'h3, 0);
        bus(1'b0, CNT, 8'h00);
        chk(r, 32'h0, 0);
        bus(1'b0, 8'h55, 8'h00);
        chk(r, 32'h0, 0);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            bus(1'b1, OPT, seed[7:0]);
            bus(1'b0, OPT, 8'h00);
            chk(r, {24'h0, seed[7:0]}, 0);
            chk({30'h0, pud, ies}, {30'h0, seed[7:6]}, 0);
        end
        bus(1'b1, OPT, 8'h08);
        for (int i = 0; i < 3; i++)
        begin
            seed = lfsr(seed);
            v = {1'b0, seed[6:0]};
            bus(1'b1, CNT, v);
            bus(1'b0, CNT, 8'h00);
            chk(r, {24'h0, v}, 0);
            repeat (38) @(posedge hclk);
            bus(1'b0, CNT, 8'h00);
            chk(r, 32'(v) + 32'(incs(40, 0)), 1);
        end
        for (int k = 0; k < 8; k++)
        begin
            bus(1'b1, OPT, 8'(k));
            bus(1'b1, CNT, 8'h00);
            repeat (40 << (k + 1)) @(posedge hclk);
            bus(1'b0, CNT, 8'h00);
            chk(r, 32'(incs(40 << (k + 1), k + 1)), 1);
        end
        bus(1'b1, CNT, 8'h00);
        repeat (800) @(posedge hclk);
        bus(1'b1, CNT, 8'h00);
        repeat (400) @(posedge hclk);
        bus(1'b0, CNT, 8'h00);
        chk(r, 32'h0, 0);
        bus(1'b1, OPT, 8'h08);
        bus(1'b1, ICT, 8'h00);
        bus(1'b1, CNT, 8'hFC);
        repeat (40) @(posedge hclk);
        bus(1'b0, ICT, 8'h00);
        chk(r, 32'h4, 0);
        chk({31'h0, irq}, 32'h0, 0);
        bus(1'b0, CNT, 8'h00);
        chk(r, 32'h5, 1);
        bus(1'b1, ICT, 8'h24);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1, 0);
        bus(1'b1, ICT, 8'h20);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0, 0);
        bus(1'b1, CTL, 8'h01);
        repeat (4) @(posedge hclk);
        bus(1'b0, CNT, 8'h00);
        v = r[7:0];
        repeat (40) @(posedge hclk);
        bus(1'b0, CNT, 8'h00);
        chk(r, {24'h0, v}, 0);
        bus(1'b1, CTL, 8'h00);
        bus(1'b1, OPT, 8'h28);
        bus(1'b1, CNT, 8'h00);
        pulses(8'h03);
        bus(1'b0, CNT, 8'h00);
        chk(r, 32'h2, 0);
        bus(1'b1, OPT, 8'h38);
        bus(1'b1, CNT, 8'h00);
        pulses(8'h01);
        bus(1'b0, CNT, 8'h00);
        chk(r, 32'h1, 0);
        bus(1'b1, OPT, 8'h20);
        bus(1'b1, CNT, 8'h00);
        pulses(8'h08);
        bus(1'b0, CNT, 8'h00);
        chk(r, 32'h2, 0);
        for (int k = 0; k < 9; k++)
        begin
            bus(1'b1, CNT, 8'h00);
            bus(1'b1, OPT, k < 8 ? 8'(8 + k) : 8'h00);
            c0 = wc;
            bus(1'b1, CTL, 8'h02);
            w0 = wt;
            repeat (192) @(posedge hclk);
            chk(32'(wc - c0), 32'h1, 0);
            chk(32'(wt - w0), 32'(64 >> (k % 8)), 1);
        end
        // Second reset in mid-run
        bus(1'b1, ICT, 8'h24);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        chk({28'h0, hready, irq, wdt_tick, wdt_clear}, 32'h0, 0);
        chk({30'h0, pud, ies}, 32'h3, 0);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, ICT, 8'h00);
        chk(r, 32'h0, 0);
        chk({31'h0, hresp}, 32'h0, 0);
        bus(1'b0, OPT, 8'h00);
        chk(r, {24'h0, timer8_pkg::OPTION_RESET}, 0);
        stop_test();
    end
endmodule
